/* File: core/sagc_consts.vh */
`ifndef SAGC_CONSTS_VH
`define SAGC_CONSTS_VH

// Register offsets
`define SAGC_ADDR_W              7
`define SAGC_OFF_LEFT_CTRL_A     7'h1a
`define SAGC_OFF_LEFT_CTRL_B     7'h1b
`define SAGC_OFF_LEFT_CTRL_C     7'h1c
`define SAGC_OFF_RIGHT_CTRL_A    7'h1d
`define SAGC_OFF_RIGHT_CTRL_B    7'h1e
`define SAGC_OFF_RIGHT_CTRL_C    7'h1f
`define SAGC_OFF_LEFT_GAIN       7'h20

// Reset values
`define SAGC_RST_CTRL_A          8'h00
`define SAGC_RST_CTRL_B          8'hfe
`define SAGC_RST_CTRL_C          8'h00
`define SAGC_RST_GAIN            8'h00
`define SAGC_RD_UNMAPPED         8'h00

// Control A fields
`define SAGC_A_ENABLE            7
`define SAGC_A_TARGET_HI         6
`define SAGC_A_TARGET_LO         4
`define SAGC_A_ATTACK_HI         3
`define SAGC_A_ATTACK_LO         2
`define SAGC_A_DECAY_HI          1
`define SAGC_A_DECAY_LO          0

// Control B fields
`define SAGC_B_MAXG_HI           7
`define SAGC_B_MAXG_LO           1

// Control C fields
`define SAGC_C_HYST_HI           7
`define SAGC_C_HYST_LO           6
`define SAGC_C_THR_HI            5
`define SAGC_C_THR_LO            1
`define SAGC_C_CLIP              0

// Decoded values, half-dB units for target and max gain, whole dB for threshold
`define SAGC_TGT_0               6'h0b
`define SAGC_TGT_1               6'h10
`define SAGC_TGT_2               6'h14
`define SAGC_TGT_3               6'h18
`define SAGC_TGT_4               6'h1c
`define SAGC_TGT_5               6'h22
`define SAGC_TGT_6               6'h28
`define SAGC_TGT_7               6'h30
`define SAGC_ATK_0               5'h08
`define SAGC_ATK_1               5'h0b
`define SAGC_ATK_2               5'h10
`define SAGC_ATK_3               5'h14
`define SAGC_DCY_0               9'h064
`define SAGC_DCY_1               9'h0c8
`define SAGC_DCY_2               9'h190
`define SAGC_DCY_3               9'h1f4
`define SAGC_MAXG_CAP            7'h77
`define SAGC_HYST_OFF_CODE       2'h3
`define SAGC_THR_BASE            7'h1c
`define SAGC_THR_OFF_CODE        5'h00

`endif

/* File: core/sagc_regs.v */
// What this block does
// [RL1] Right AGC enable follows control A bit 7
// [RL2] Right target level decoded from three-bit code
// [RL3] Right attack time 8/11/16/20 ms
// [RL4] Right decay time 100/200/400/500 ms
// [RL5] Times valid only without double rate audio
// [RL6] Right max gain half-dB steps, capped 59.5
// [RL7] Host writes zero to max-gain low bit
// [RL8] Right hysteresis 1/2/3 dB or off
// [RL9] Right threshold code zero disables detection
// [RL10] Right threshold -30 dB falling 2 dB/code
// [RL11] Left threshold decoded same as right
// [RL12] Left clip stepping follows control C bit 0
// [RL13] Right clip stepping follows control C bit 0
// [RL14] Left applied gain readable, signed half-dB
// [RL15] Reset values: max gain all ones, rest zero
// [RL16] Left channel has own A/B fields
// [RL17] Left control C carries hysteresis field
// [RL18] Gain readback tracks applied gain continuously
`timescale 1ns/1ps
`default_nettype none
`include "sagc_consts.vh"

module sagc_chan_decode (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       sys_rst,
  // Raw control registers
  input  wire [7:0] ctrl_a,
  input  wire [7:0] ctrl_b,
  input  wire [7:0] ctrl_c,
  // Decoded settings
  output reg        agc_enable,
  output reg  [5:0] target_half_db,
  output reg  [4:0] attack_ms,
  output reg  [8:0] decay_ms,
  output reg  [6:0] max_gain_half_db,
  output reg        hyst_enable,
  output reg  [1:0] hyst_db,
  output reg        detect_enable,
  output reg  [6:0] noise_thr_db,
  output reg        clip_step_enable
);

  wire [2:0] target_code;
  wire [1:0] attack_code;
  wire [1:0] decay_code;
  wire [6:0] max_gain_code;
  wire [1:0] hyst_code;
  wire [4:0] thr_code;
  reg  [5:0] target_next;
  reg  [4:0] attack_next;
  reg  [8:0] decay_next;
  reg  [6:0] max_gain_next;
  reg  [6:0] thr_next;

  assign target_code   = ctrl_a[`SAGC_A_TARGET_HI:`SAGC_A_TARGET_LO];
  assign attack_code   = ctrl_a[`SAGC_A_ATTACK_HI:`SAGC_A_ATTACK_LO];
  assign decay_code    = ctrl_a[`SAGC_A_DECAY_HI:`SAGC_A_DECAY_LO];
  assign max_gain_code = ctrl_b[`SAGC_B_MAXG_HI:`SAGC_B_MAXG_LO];
  assign hyst_code     = ctrl_c[`SAGC_C_HYST_HI:`SAGC_C_HYST_LO];
  assign thr_code      = ctrl_c[`SAGC_C_THR_HI:`SAGC_C_THR_LO];

  always @* begin
    case (target_code) // [RL2]
      3'h0:    target_next = `SAGC_TGT_0;
      3'h1:    target_next = `SAGC_TGT_1;
      3'h2:    target_next = `SAGC_TGT_2;
      3'h3:    target_next = `SAGC_TGT_3;
      3'h4:    target_next = `SAGC_TGT_4;
      3'h5:    target_next = `SAGC_TGT_5;
      3'h6:    target_next = `SAGC_TGT_6;
      default: target_next = `SAGC_TGT_7;
    endcase
  end

  always @* begin
    case (attack_code) // [RL3]
      2'h0:    attack_next = `SAGC_ATK_0;
      2'h1:    attack_next = `SAGC_ATK_1;
      2'h2:    attack_next = `SAGC_ATK_2;
      default: attack_next = `SAGC_ATK_3;
    endcase
  end

  always @* begin
    case (decay_code) // [RL4]
      2'h0:    decay_next = `SAGC_DCY_0;
      2'h1:    decay_next = `SAGC_DCY_1;
      2'h2:    decay_next = `SAGC_DCY_2;
      default: decay_next = `SAGC_DCY_3;
    endcase
  end

  always @* begin
    // Codes past the cap all mean 59.5 dB
    if (max_gain_code > `SAGC_MAXG_CAP) begin // [RL6]
      max_gain_next = `SAGC_MAXG_CAP;
    end else begin
      max_gain_next = max_gain_code;
    end
  end

  always @* begin
    // Code 1 gives 30 dB, each step adds 2 dB of depth
    if (thr_code == `SAGC_THR_OFF_CODE) begin // [RL9] [RL11]
      thr_next = 7'h00;
    end else begin
      thr_next = `SAGC_THR_BASE + {1'b0, thr_code, 1'b0}; // [RL10] [RL11]
    end
  end

  // Outputs registered one cycle after the raw fields
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      agc_enable       <= 1'b0;
      target_half_db   <= `SAGC_TGT_0;
      attack_ms        <= `SAGC_ATK_0;
      decay_ms         <= `SAGC_DCY_0;
      max_gain_half_db <= `SAGC_MAXG_CAP;
      hyst_enable      <= 1'b1;
      hyst_db          <= 2'h1;
      detect_enable    <= 1'b0;
      noise_thr_db     <= 7'h00;
      clip_step_enable <= 1'b0;
    end else begin
      agc_enable       <= ctrl_a[`SAGC_A_ENABLE]; // [RL1] [RL16]
      target_half_db   <= target_next;
      attack_ms        <= attack_next;
      decay_ms         <= decay_next;
      max_gain_half_db <= max_gain_next;
      hyst_enable      <= (hyst_code != `SAGC_HYST_OFF_CODE); // [RL8] [RL17]
      hyst_db          <= hyst_code + 2'h1;
      detect_enable    <= (thr_code != `SAGC_THR_OFF_CODE); // [RL9]
      noise_thr_db     <= thr_next;
      clip_step_enable <= ctrl_c[`SAGC_C_CLIP]; // [RL12] [RL13]
    end
  end

endmodule

module sagc_regs (
  // Clock and reset
  input  wire                    ref_clk,
  input  wire                    sys_rst,
  // Register port
  input  wire [`SAGC_ADDR_W-1:0] reg_addr,
  input  wire                    reg_wr_en,
  input  wire [7:0]              reg_wr_data,
  input  wire                    reg_rd_en,
  output reg  [7:0]              reg_rd_data,
  // Gain engine status
  input  wire [7:0]              left_applied_gain,
  input  wire                    double_rate_audio,
  // Timing validity
  output reg                     agc_times_valid,
  // Left channel settings
  output wire                    left_agc_enable,
  output wire [5:0]              left_target_half_db,
  output wire [4:0]              left_attack_ms,
  output wire [8:0]              left_decay_ms,
  output wire [6:0]              left_max_gain_half_db,
  output wire                    left_hyst_enable,
  output wire [1:0]              left_hyst_db,
  output wire                    left_detect_enable,
  output wire [6:0]              left_noise_thr_db,
  output wire                    left_clip_step_enable,
  // Right channel settings
  output wire                    right_agc_enable,
  output wire [5:0]              right_target_half_db,
  output wire [4:0]              right_attack_ms,
  output wire [8:0]              right_decay_ms,
  output wire [6:0]              right_max_gain_half_db,
  output wire                    right_hyst_enable,
  output wire [1:0]              right_hyst_db,
  output wire                    right_detect_enable,
  output wire [6:0]              right_noise_thr_db,
  output wire                    right_clip_step_enable
);

  reg [7:0] left_ctrl_a_reg;
  reg [7:0] left_ctrl_b_reg;
  reg [7:0] left_ctrl_c_reg;
  reg [7:0] right_ctrl_a_reg;
  reg [7:0] right_ctrl_b_reg;
  reg [7:0] right_ctrl_c_reg;
  reg [7:0] left_gain_reg;
  reg [7:0] rd_data_next;

  // Control registers; the max-gain low bit is stored as written,
  // host is expected to keep it zero [RL7]
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      left_ctrl_a_reg  <= `SAGC_RST_CTRL_A; // [RL15] [RL16]
      left_ctrl_b_reg  <= `SAGC_RST_CTRL_B; // [RL16]
      left_ctrl_c_reg  <= `SAGC_RST_CTRL_C;
      right_ctrl_a_reg <= `SAGC_RST_CTRL_A; // [RL15]
      right_ctrl_b_reg <= `SAGC_RST_CTRL_B; // [RL15]
      right_ctrl_c_reg <= `SAGC_RST_CTRL_C;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `SAGC_OFF_LEFT_CTRL_A:  left_ctrl_a_reg  <= reg_wr_data;
        `SAGC_OFF_LEFT_CTRL_B:  left_ctrl_b_reg  <= reg_wr_data;
        `SAGC_OFF_LEFT_CTRL_C:  left_ctrl_c_reg  <= reg_wr_data;
        `SAGC_OFF_RIGHT_CTRL_A: right_ctrl_a_reg <= reg_wr_data;
        `SAGC_OFF_RIGHT_CTRL_B: right_ctrl_b_reg <= reg_wr_data;
        `SAGC_OFF_RIGHT_CTRL_C: right_ctrl_c_reg <= reg_wr_data;
        // Readback and unmapped addresses ignore writes
        default: left_ctrl_a_reg <= left_ctrl_a_reg;
      endcase
    end
  end

  // Gain source is on this clock, so no synchroniser
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      left_gain_reg <= `SAGC_RST_GAIN; // [RL15]
    end else begin
      left_gain_reg <= left_applied_gain; // [RL14] [RL18]
    end
  end

  // Times only hold at normal rate
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      agc_times_valid <= 1'b1;
    end else begin
      agc_times_valid <= ~double_rate_audio; // [RL5]
    end
  end

  always @* begin
    case (reg_addr)
      `SAGC_OFF_LEFT_CTRL_A:  rd_data_next = left_ctrl_a_reg;
      `SAGC_OFF_LEFT_CTRL_B:  rd_data_next = left_ctrl_b_reg;
      `SAGC_OFF_LEFT_CTRL_C:  rd_data_next = left_ctrl_c_reg;
      `SAGC_OFF_RIGHT_CTRL_A: rd_data_next = right_ctrl_a_reg;
      `SAGC_OFF_RIGHT_CTRL_B: rd_data_next = right_ctrl_b_reg;
      `SAGC_OFF_RIGHT_CTRL_C: rd_data_next = right_ctrl_c_reg;
      `SAGC_OFF_LEFT_GAIN:    rd_data_next = left_gain_reg; // [RL14]
      default:                rd_data_next = `SAGC_RD_UNMAPPED;
    endcase
  end

  // Read data holds until the next read strobe
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rd_data <= `SAGC_RD_UNMAPPED;
    end else if (reg_rd_en) begin
      reg_rd_data <= rd_data_next;
    end
  end

  sagc_chan_decode u_left (
    .ref_clk          (ref_clk),
    .sys_rst          (sys_rst),
    .ctrl_a           (left_ctrl_a_reg),
    .ctrl_b           (left_ctrl_b_reg),
    .ctrl_c           (left_ctrl_c_reg),
    .agc_enable       (left_agc_enable),
    .target_half_db   (left_target_half_db),
    .attack_ms        (left_attack_ms),
    .decay_ms         (left_decay_ms),
    .max_gain_half_db (left_max_gain_half_db),
    .hyst_enable      (left_hyst_enable),
    .hyst_db          (left_hyst_db),
    .detect_enable    (left_detect_enable),
    .noise_thr_db     (left_noise_thr_db),
    .clip_step_enable (left_clip_step_enable)
  );

  sagc_chan_decode u_right (
    .ref_clk          (ref_clk),
    .sys_rst          (sys_rst),
    .ctrl_a           (right_ctrl_a_reg),
    .ctrl_b           (right_ctrl_b_reg),
    .ctrl_c           (right_ctrl_c_reg),
    .agc_enable       (right_agc_enable),
    .target_half_db   (right_target_half_db),
    .attack_ms        (right_attack_ms),
    .decay_ms         (right_decay_ms),
    .max_gain_half_db (right_max_gain_half_db),
    .hyst_enable      (right_hyst_enable),
    .hyst_db          (right_hyst_db),
    .detect_enable    (right_detect_enable),
    .noise_thr_db     (right_noise_thr_db),
    .clip_step_enable (right_clip_step_enable)
  );

endmodule
`default_nettype wire

/* File: tb/sagc_regs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sagc_regs_checker (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  // Register port
  input wire logic [6:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  // Engine status
  input wire logic [7:0] left_applied_gain,
  input wire logic       double_rate_audio,
  input wire logic       agc_times_valid,
  // Decoded settings
  input wire logic       right_agc_enable,
  input wire logic [6:0] right_max_gain_half_db,
  input wire logic       right_hyst_enable,
  input wire logic       right_detect_enable,
  input wire logic [6:0] right_noise_thr_db,
  input wire logic       left_detect_enable,
  input wire logic       left_clip_step_enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic wr_ra = reg_wr_en && reg_addr == 7'h1d;
  wire logic wr_rb = reg_wr_en && reg_addr == 7'h1e;
  wire logic wr_rc = reg_wr_en && reg_addr == 7'h1f;
  wire logic wr_lc = reg_wr_en && reg_addr == 7'h1c;

  // Gain register lags the engine by one edge, so a read shows it two edges back
  AST_RD_GAIN: assert property (reg_rd_en && reg_addr == 7'h20 && !$past(sys_rst)
    |=> reg_rd_data == $past(left_applied_gain, 2)) else $error("gain readback wrong");
  AST_RD_HOLD: assert property (!reg_rd_en |=> $stable(reg_rd_data))
    else $error("read data moved without read");
  AST_EN_RIGHT: assert property (wr_ra |=> ##1 right_agc_enable == $past(reg_wr_data[7], 2))
    else $error("right enable wrong");
  AST_MAXG_RIGHT: assert property (wr_rb |=> ##1 right_max_gain_half_db ==
    ($past(reg_wr_data[7:1], 2) > 7'h77 ? 7'h77 : $past(reg_wr_data[7:1], 2))) else $error("max gain wrong");
  AST_HYST_RIGHT: assert property (wr_rc |=> ##1 right_hyst_enable == ($past(reg_wr_data[7:6], 2) != 2'h3))
    else $error("hysteresis enable wrong");
  AST_DET_RIGHT: assert property (wr_rc |=> ##1 right_detect_enable == ($past(reg_wr_data[5:1], 2) != 5'h00))
    else $error("right detect wrong");
  AST_THR_RIGHT: assert property (wr_rc && reg_wr_data[5:1] != 5'h00
    |=> ##1 right_noise_thr_db == 7'h1c + {1'b0, $past(reg_wr_data[5:1], 2), 1'b0}) else $error("threshold wrong");
  AST_DET_LEFT: assert property (wr_lc |=> ##1 left_detect_enable == ($past(reg_wr_data[5:1], 2) != 5'h00))
    else $error("left detect wrong");
  AST_CLIP_LEFT: assert property (wr_lc |=> ##1 left_clip_step_enable == $past(reg_wr_data[0], 2))
    else $error("left clip wrong");
  AST_DRA: assert property (double_rate_audio |=> !agc_times_valid)
    else $error("times flagged valid in double rate");
  AST_DRA_OFF: assert property (!double_rate_audio |=> agc_times_valid)
    else $error("times flagged invalid at normal rate");
endmodule
`default_nettype wire

/* File: tb/sagc_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sagc_regs_test;
  // Design ports
  logic       ref_clk, sys_rst, reg_wr_en, reg_rd_en, double_rate_audio;
  logic [6:0] reg_addr;
  logic [7:0] reg_wr_data, left_applied_gain;
  wire  [7:0] reg_rd_data;
  wire        agc_times_valid, left_agc_enable, right_agc_enable, left_hyst_enable, right_hyst_enable;
  wire        left_detect_enable, right_detect_enable, left_clip_step_enable, right_clip_step_enable;
  wire  [5:0] left_target_half_db, right_target_half_db;
  wire  [4:0] left_attack_ms, right_attack_ms;
  wire  [8:0] left_decay_ms, right_decay_ms;
  wire  [6:0] left_max_gain_half_db, right_max_gain_half_db, left_noise_thr_db, right_noise_thr_db;
  wire  [1:0] left_hyst_db, right_hyst_db;
  // Bench state
  integer     seed = 82, n_errors = 0, check_count = 0, i, k;
  logic       rd_seen = 1'b0;
  logic [7:0] d, sh [6], expq [$];
  logic [7:0] mgl [5] = '{8'h00, 8'hec, 8'hee, 8'hf0, 8'hfe};
  logic [5:0] tg [8] = '{6'h0b, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h22, 6'h28, 6'h30};
  logic [4:0] ak [4] = '{5'h08, 5'h0b, 5'h10, 5'h14};
  logic [8:0] dk [4] = '{9'h064, 9'h0c8, 9'h190, 9'h1f4};

  sagc_regs i_sagc_regs (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .left_applied_gain(left_applied_gain), .double_rate_audio(double_rate_audio),
    .agc_times_valid(agc_times_valid), .left_agc_enable(left_agc_enable),
    .left_target_half_db(left_target_half_db), .left_attack_ms(left_attack_ms), .left_decay_ms(left_decay_ms),
    .left_max_gain_half_db(left_max_gain_half_db), .left_hyst_enable(left_hyst_enable),
    .left_hyst_db(left_hyst_db), .left_detect_enable(left_detect_enable),
    .left_noise_thr_db(left_noise_thr_db), .left_clip_step_enable(left_clip_step_enable),
    .right_agc_enable(right_agc_enable), .right_target_half_db(right_target_half_db),
    .right_attack_ms(right_attack_ms), .right_decay_ms(right_decay_ms),
    .right_max_gain_half_db(right_max_gain_half_db), .right_hyst_enable(right_hyst_enable),
    .right_hyst_db(right_hyst_db), .right_detect_enable(right_detect_enable),
    .right_noise_thr_db(right_noise_thr_db), .right_clip_step_enable(right_clip_step_enable));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input string nm, input logic [39:0] s, e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [39:0] exp_dec(input logic [7:0] a, b, c);
    logic [4:0] t;
    t = c[5:1];
    return {a[7], tg[a[6:4]], ak[a[3:2]], dk[a[1:0]], (b[7:1] > 7'h77) ? 7'h77 : b[7:1], c[7:6] != 2'h3,
            c[7:6] + 2'h1, t != 5'h00, (t == 5'h00) ? 7'h00 : 7'h1c + {1'b0, t, 1'b0}, c[0]};
  endfunction

  task automatic chk_all;
    logic [39:0] lv, rv;
    lv = {left_agc_enable, left_target_half_db, left_attack_ms, left_decay_ms, left_max_gain_half_db,
          left_hyst_enable, left_hyst_db, left_detect_enable, left_noise_thr_db, left_clip_step_enable};
    rv = {right_agc_enable, right_target_half_db, right_attack_ms, right_decay_ms, right_max_gain_half_db,
          right_hyst_enable, right_hyst_db, right_detect_enable, right_noise_thr_db, right_clip_step_enable};
    check("left_dec", lv, exp_dec(sh[0], sh[1], sh[2]));
    check("right_dec", rv, exp_dec(sh[3], sh[4], sh[5]));
    check("times_valid", agc_times_valid, !double_rate_audio);
  endtask

  // Write, then let the decode stage catch up before anything looks
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wr_data = v;
    reg_wr_en = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr_en = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  // Gain input changes with the read, so a stale register shows up
  task automatic rd(input logic [6:0] a, input logic [7:0] e, g);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd_en = 1'b1;
    left_applied_gain = g;
    expq.push_back(e);
    @(posedge ref_clk);
    #1;
    reg_rd_en = 1'b0;
  endtask

  task automatic rd_all;
    for (k = 0; k < 6; k++)
      rd(7'(26 + k), sh[k], left_applied_gain);
  endtask

  task automatic rst_pulse;
    @(posedge ref_clk);
    #1;
    sys_rst = 1'b1;
    double_rate_audio = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    check("rd_in_reset", reg_rd_data, 8'h00);
    sys_rst = 1'b0;
    // First edge after release still sees the reset gain value
    reg_addr = 7'h20;
    reg_rd_en = 1'b1;
    expq.push_back(8'h00);
    sh = '{8'h00, 8'hfe, 8'h00, 8'h00, 8'hfe, 8'h00};
    chk_all;
    rd_all;
    $display("reset test done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (rd_seen && expq.size() > 0)
      check("rd_data", reg_rd_data, expq.pop_front());
    rd_seen <= reg_rd_en & ~sys_rst;
  end

  initial begin
    #3000000;
    n_errors++;
    conclude;
  end

  initial begin
    {sys_rst, reg_wr_en, reg_rd_en, double_rate_audio} = 4'h8;
    reg_addr = 7'h00;
    reg_wr_data = 8'h00;
    left_applied_gain = 8'h00;
    rst_pulse;
    // Codes around the 59.5 dB cap
    for (i = 0; i < 5; i++) begin
      sh[4] = mgl[i];
      wr(7'h1e, mgl[i]);
      chk_all;
    end
    $display("max gain test done");
    for (i = 0; i < 300; i++) begin
      k = $unsigned($random(seed)) % 6;
      d = 8'($random(seed));
      if (k == 1 || k == 4)
        d[0] = 1'b0;
      double_rate_audio = d[3];
      sh[k] = d;
      wr(7'(26 + k), d);
      chk_all;
      rd(7'(26 + k), sh[k], 8'($random(seed)));
      rd(7'h20, left_applied_gain, 8'($random(seed)));
    end
    $display("random test done");
    // Read-only and unmapped places
    wr(7'h20, 8'h5a);
    wr(7'h21, 8'hff);
    wr(7'h19, 8'hff);
    rd(7'h20, left_applied_gain, 8'he8);
    rd(7'h19, 8'h00, 8'h77);
    rd(7'h21, 8'h00, 8'h77);
    rd(7'h7f, 8'h00, 8'h00);
    rd_all;
    chk_all;
    $display("refused access test done");
    rst_pulse;
    conclude;
  end
endmodule

bind sagc_regs sagc_regs_checker i_sagc_regs_checker (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .left_applied_gain(left_applied_gain),
  .double_rate_audio(double_rate_audio), .agc_times_valid(agc_times_valid), .right_agc_enable(right_agc_enable),
  .right_max_gain_half_db(right_max_gain_half_db), .right_hyst_enable(right_hyst_enable),
  .right_detect_enable(right_detect_enable), .right_noise_thr_db(right_noise_thr_db),
  .left_detect_enable(left_detect_enable), .left_clip_step_enable(left_clip_step_enable));
`default_nettype wire
